//--- core/bct_core.v
// capture and trigger control of a parallel bus analyzer
`timescale 1ns/1ps
`include "bct_consts.vh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - a run starts capture in state or timing view; bad mode gives 0xFFFE, absent 0xFFFF.
// - activity is always stored as timing events; state lines derive from them.
// - a length query stops capture and returns the line count of the run's view.
// - trigger none, immediate, arbitration, (re)selection or transfer byte, default immediate.
// - parity and data lines are compared under a per-bit mask, default all don't care.
// - the trigger fires after the programmed count of matches, 0 to 65535, default one.
// - trigger position before (95% after), centered, or after (95% before); default before.
// - a byte fetch searches from first event, last event, forward or backward from the trigger.
// - a byte fetch finds the requested occurrence of the chosen line type.
// - fetch offsets reach 4095 but stay inside the found line; an offset past its last byte fails the fetch.
// - byte fetch status has a distinct code per failure, except bad type and zero count, which share one.
// - status encodes running pre-trigger, running post-trigger, stopped full, and stopped.
module bct_core #(
   parameter DEPTH_LOG2 = 10,
   parameter PRESENT    = 1
) (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire        ev_valid,
   input  wire [3:0]  ev_phase,
   input  wire        ev_xfer,
   input  wire [8:0]  data_parity_line,
   output reg  [15:0] reg_rdata,
   output reg         capturing
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   localparam [1:0] F_IDLE = 2'h0;
   localparam [1:0] F_SCAN = 2'h1;
   localparam [1:0] F_BYTE = 2'h2;

   // event store: phase, transfer flag, parity plus data
   reg  [13:0]           mem [0:DEPTH-1];
   reg  [DEPTH_LOG2-1:0] wptr;
   reg  [DEPTH_LOG2:0]   fill;
   reg  [DEPTH_LOG2-1:0] trig_idx;
   reg  [DEPTH_LOG2:0]   post_cnt;
   reg                   trig_rec;
   reg                   full;
   reg  [1:0]            mode;
   reg  [15:0]           run_res;
   reg  [15:0]           state_lines;
   reg  [3:0]            trig_cond;
   reg  [8:0]            trig_mask;
   reg  [8:0]            trig_val;
   reg  [15:0]           trig_cnt;
   reg  [1:0]            trig_pos;
   reg                   arm;
   reg  [3:0]            last_phase;
   reg  [1:0]            f_state;
   reg  [1:0]            f_ref;
   reg  [3:0]            f_type;
   reg  [15:0]           f_cnt;
   reg  [11:0]           f_ofs;
   reg  [15:0]           f_seen;
   reg  [DEPTH_LOG2-1:0] f_ptr;
   reg  [DEPTH_LOG2:0]   f_left;
   reg  [3:0]            f_prev;
   reg  [7:0]            f_status;
   reg  [7:0]            f_byte;
   reg                   f_busy;
   wire                  fired;
   wire [13:0]           rd_word;
   wire [DEPTH_LOG2:0]   post_limit;
   wire                  new_line;
   wire                  line_start;

   // first index of the stored window, oldest first
   function [DEPTH_LOG2-1:0] oldest;
      input [DEPTH_LOG2-1:0] wp;
      input [DEPTH_LOG2:0]   fl;
      begin
         oldest = wp - fl[DEPTH_LOG2-1:0];
      end
   endfunction

   // percentage of depth, used for the post-trigger budget
   function [DEPTH_LOG2:0] pct_of_depth;
      input [6:0] pct;
      reg   [DEPTH_LOG2+7:0] prod;
      begin
         prod = {1'b1, {DEPTH_LOG2{1'b0}}} * pct / `BCT_PCT_FULL;
         pct_of_depth = prod[DEPTH_LOG2:0];
      end
   endfunction

   assign post_limit = (trig_pos == `BCT_POS_BEFORE) ? pct_of_depth(`BCT_PCT_MAJOR) :
                       (trig_pos == `BCT_POS_AFTER)  ?
                          pct_of_depth(`BCT_PCT_FULL - `BCT_PCT_MAJOR) :
                          pct_of_depth(7'h32);
   assign rd_word  = mem[f_ptr];
   assign new_line = ev_valid && (ev_phase != last_phase);
   // backward hits stop at a line's first record, where the older one differs
   assign line_start = rd_word[13:10] == f_type && (f_ref[0] ?
                       (f_ptr == oldest(wptr, fill) ||
                        mem[f_ptr - {{(DEPTH_LOG2-1){1'b0}}, 1'b1}][13:10] != f_type) :
                       f_prev != f_type);

   bct_trigger u_trig (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .arm      (arm),
      .active   (capturing),
      .cond     (trig_cond),
      .mask     (trig_mask),
      .value    (trig_val),
      .count    (trig_cnt),
      .ev_valid (ev_valid),
      .ev_phase (ev_phase),
      .ev_xfer  (ev_xfer),
      .ev_data  (data_parity_line),
      .fired    (fired)
   );

   //////////////////////////////////////////////////////////////////////////////
   // configuration and run control
   always @(posedge core_clk) begin
      if (!rst_n) begin
         mode      <= `BCT_MODE_TIMING;
         run_res   <= `BCT_OK;
         trig_cond <= `BCT_TC_IMMEDIATE;
         trig_mask <= 9'h000;
         trig_val  <= 9'h000;
         trig_cnt  <= `BCT_DEF_COUNT;
         trig_pos  <= `BCT_POS_BEFORE;
         arm       <= 1'b0;
      end else begin
         arm <= 1'b0;
         if (reg_wr) begin
            case (reg_addr)
               `BCT_REG_RUN: begin
                  if (PRESENT == 0) begin
                     run_res <= `BCT_ERR_ABSENT;
                  end else if (reg_wdata[1:0] == `BCT_MODE_STATE ||
                               reg_wdata[1:0] == `BCT_MODE_TIMING) begin
                     mode    <= reg_wdata[1:0];
                     run_res <= `BCT_OK;
                     arm     <= 1'b1;
                  end else begin
                     run_res <= `BCT_ERR_MODE;
                  end
               end
               `BCT_REG_TRIG_COND: trig_cond <= reg_wdata[3:0];
               `BCT_REG_TRIG_MASK: trig_mask <= reg_wdata[8:0];
               `BCT_REG_TRIG_VAL:  trig_val  <= reg_wdata[8:0];
               `BCT_REG_TRIG_CNT:  trig_cnt  <= reg_wdata;
               `BCT_REG_TRIG_POS:  trig_pos  <= reg_wdata[1:0];
               default: ;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // capture into the event store; the buffer wraps until the post budget ends
   always @(posedge core_clk) begin
      if (!rst_n) begin
         capturing   <= 1'b0;
         wptr        <= {DEPTH_LOG2{1'b0}};
         fill        <= {(DEPTH_LOG2+1){1'b0}};
         trig_idx    <= {DEPTH_LOG2{1'b0}};
         trig_rec    <= 1'b0;
         post_cnt    <= {(DEPTH_LOG2+1){1'b0}};
         full        <= 1'b0;
         state_lines <= 16'h0000;
         last_phase  <= 4'h0;
      end else if (arm) begin
         capturing   <= 1'b1;
         wptr        <= {DEPTH_LOG2{1'b0}};
         fill        <= {(DEPTH_LOG2+1){1'b0}};
         trig_rec    <= 1'b0;
         post_cnt    <= {(DEPTH_LOG2+1){1'b0}};
         full        <= 1'b0;
         state_lines <= 16'h0000;
         last_phase  <= 4'h0;
      end else if (reg_rd && reg_addr == `BCT_REG_LENGTH) begin
         capturing <= 1'b0;
      end else if (capturing) begin
         if (fired && !trig_rec) begin
            trig_rec <= 1'b1;
            trig_idx <= wptr - {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
         end
         if (ev_valid) begin
            // every event is a timing record; state lines are counted from it
            mem[wptr] <= {ev_phase, ev_xfer, data_parity_line};
            wptr      <= wptr + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
            if (fill != DEPTH[DEPTH_LOG2:0]) begin
               fill <= fill + {{DEPTH_LOG2{1'b0}}, 1'b1};
            end
            if (new_line) begin
               last_phase  <= ev_phase;
               state_lines <= state_lines + 16'h0001;
            end
            if (trig_rec || fired) begin
               post_cnt <= post_cnt + {{DEPTH_LOG2{1'b0}}, 1'b1};
               if (post_cnt + {{DEPTH_LOG2{1'b0}}, 1'b1} >= post_limit) begin
                  capturing <= 1'b0;
                  full      <= 1'b1;
               end
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // byte fetch engine: walks the store one record per cycle
   always @(posedge core_clk) begin
      if (!rst_n) begin
         f_state  <= F_IDLE;
         f_busy   <= 1'b0;
         f_status <= `BCT_FS_OK;
         f_byte   <= 8'h00;
         f_ref    <= `BCT_REF_FIRST;
         f_type   <= `BCT_PH_ARB;
         f_cnt    <= `BCT_DEF_COUNT;
         f_ofs    <= 12'h000;
         f_seen   <= 16'h0000;
         f_ptr    <= {DEPTH_LOG2{1'b0}};
         f_left   <= {(DEPTH_LOG2+1){1'b0}};
         f_prev   <= 4'h0;
      end else begin
         case (f_state)
            F_IDLE: begin
               if (reg_wr && reg_addr == `BCT_REG_FETCH_CNT) begin
                  f_cnt <= reg_wdata;
               end
               if (reg_wr && reg_addr == `BCT_REG_FETCH_OFS) begin
                  f_ofs <= reg_wdata[11:0] & `BCT_MAX_OFFSET;
               end
               if (reg_wr && reg_addr == `BCT_REG_FETCH_CTL) begin
                  f_ref  <= reg_wdata[1:0];
                  f_type <= reg_wdata[7:4];
                  f_seen <= 16'h0000;
                  f_prev <= 4'h0;
                  f_busy <= 1'b1;
                  // error checks first, in a fixed priority order
                  if (fill == {(DEPTH_LOG2+1){1'b0}}) begin
                     f_status <= `BCT_FS_EMPTY;
                     f_busy   <= 1'b0;
                  end else if (mode != `BCT_MODE_STATE) begin
                     f_status <= `BCT_FS_NOT_STATE;
                     f_busy   <= 1'b0;
                  end else if (reg_wdata[7:4] < `BCT_PH_ARB ||
                               reg_wdata[7:4] > `BCT_PH_MSG_IN ||
                               f_cnt == 16'h0000) begin
                     f_status <= `BCT_FS_BAD_TYPE;
                     f_busy   <= 1'b0;
                  end else if (reg_wdata[3:2] != 2'b00) begin
                     f_status <= `BCT_FS_BAD_REF;
                     f_busy   <= 1'b0;
                  end else if (reg_wdata[1] && !trig_rec) begin
                     f_status <= `BCT_FS_NO_TRIG;
                     f_busy   <= 1'b0;
                  end else begin
                     f_state <= F_SCAN;
                     case (reg_wdata[1:0])
                        `BCT_REF_FIRST: begin
                           f_ptr  <= oldest(wptr, fill);
                           f_left <= fill;
                        end
                        `BCT_REF_LAST: begin
                           f_ptr  <= wptr - {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
                           f_left <= fill;
                        end
                        `BCT_REF_FWD_TRIG: begin
                           f_ptr  <= trig_idx;
                           f_left <= {1'b0, wptr - trig_idx};
                        end
                        default: begin
                           f_ptr  <= trig_idx;
                           f_left <= {1'b0, trig_idx - oldest(wptr, fill)} +
                                     {{DEPTH_LOG2{1'b0}}, 1'b1};
                        end
                     endcase
                  end
               end
            end
            F_SCAN: begin
               if (f_left == {(DEPTH_LOG2+1){1'b0}}) begin
                  f_status <= `BCT_FS_NO_PHASE;
                  f_busy   <= 1'b0;
                  f_state  <= F_IDLE;
               end else begin
                  f_prev <= rd_word[13:10];
                  f_left <= f_left - {{DEPTH_LOG2{1'b0}}, 1'b1};
                  if (line_start) begin
                     f_seen <= f_seen + 16'h0001;
                  end
                  if (line_start && f_seen + 16'h0001 == f_cnt) begin
                     f_state <= F_BYTE;
                     f_left  <= fill - {1'b0, f_ptr - oldest(wptr, fill)};
                  end else begin
                     f_ptr <= f_ref[0] ? f_ptr - {{(DEPTH_LOG2-1){1'b0}}, 1'b1}
                                       : f_ptr + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
                  end
               end
            end
            F_BYTE: begin
               // bytes are taken forward through records of the same phase,
               // so offsets past one line end the fetch with no byte
               if (f_left == {(DEPTH_LOG2+1){1'b0}} || rd_word[13:10] != f_type) begin
                  f_status <= `BCT_FS_NO_BYTE;
                  f_busy   <= 1'b0;
                  f_state  <= F_IDLE;
               end else if (!rd_word[9]) begin
                  f_ptr  <= f_ptr + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
                  f_left <= f_left - {{DEPTH_LOG2{1'b0}}, 1'b1};
               end else if (f_ofs == 12'h000) begin
                  f_byte   <= rd_word[7:0];
                  f_status <= `BCT_FS_OK;
                  f_busy   <= 1'b0;
                  f_state  <= F_IDLE;
               end else begin
                  f_ofs  <= f_ofs - 12'h001;
                  f_ptr  <= f_ptr + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
                  f_left <= f_left - {{DEPTH_LOG2{1'b0}}, 1'b1};
               end
            end
            default: f_state <= F_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after the strobe
   always @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `BCT_REG_TRIG_COND: reg_rdata <= {12'h000, trig_cond};
            `BCT_REG_TRIG_MASK: reg_rdata <= {7'h00, trig_mask};
            `BCT_REG_TRIG_VAL:  reg_rdata <= {7'h00, trig_val};
            `BCT_REG_TRIG_CNT:  reg_rdata <= trig_cnt;
            `BCT_REG_TRIG_POS:  reg_rdata <= {14'h0000, trig_pos};
            `BCT_REG_STATUS: begin
               if (PRESENT == 0)            reg_rdata <= `BCT_ERR_ABSENT;
               else if (capturing && !trig_rec) reg_rdata <= `BCT_ST_PRE;
               else if (capturing)          reg_rdata <= `BCT_ST_POST;
               else if (trig_rec && full)   reg_rdata <= `BCT_ST_FULL;
               else                         reg_rdata <= `BCT_ST_STOP;
            end
            `BCT_REG_RUN_RES:   reg_rdata <= run_res;
            `BCT_REG_LENGTH: begin
               if (mode == `BCT_MODE_STATE) reg_rdata <= state_lines;
               else reg_rdata <= {{(15-DEPTH_LOG2){1'b0}}, fill};
            end
            `BCT_REG_FETCH_CTL: reg_rdata <= {7'h00, f_busy, f_type, 2'h0, f_ref};
            `BCT_REG_FETCH_CNT: reg_rdata <= f_cnt;
            `BCT_REG_FETCH_OFS: reg_rdata <= {4'h0, f_ofs};
            `BCT_REG_FETCH_RES: reg_rdata <= {f_status, f_byte};
            default:            reg_rdata <= 16'h0000;
         endcase
      end
   end
endmodule

//--- core/bct_consts.vh
// constants for the bus capture and trigger control block
`ifndef BCT_CONSTS_VH
`define BCT_CONSTS_VH

// register offsets (word index on the plain register port)
`define BCT_REG_RUN        4'h0
`define BCT_REG_TRIG_COND  4'h1
`define BCT_REG_TRIG_MASK  4'h2
`define BCT_REG_TRIG_VAL   4'h3
`define BCT_REG_TRIG_CNT   4'h4
`define BCT_REG_TRIG_POS   4'h5
`define BCT_REG_STATUS     4'h6
`define BCT_REG_RUN_RES    4'h7
`define BCT_REG_LENGTH     4'h8
`define BCT_REG_FETCH_CTL  4'h9
`define BCT_REG_FETCH_CNT  4'hA
`define BCT_REG_FETCH_OFS  4'hB
`define BCT_REG_FETCH_RES  4'hC

// run modes
`define BCT_MODE_STATE     2'h1
`define BCT_MODE_TIMING    2'h2

// result codes
`define BCT_OK             16'h0000
`define BCT_ERR_MODE       16'hFFFE
`define BCT_ERR_ABSENT     16'hFFFF

// trigger conditions
`define BCT_TC_NONE        4'h0
`define BCT_TC_IMMEDIATE   4'h1
`define BCT_TC_ARB         4'h2
`define BCT_TC_SEL         4'h3
`define BCT_TC_RESEL       4'h4
`define BCT_TC_MSG_OUT     4'h5
`define BCT_TC_CMD         4'h6
`define BCT_TC_DATA_OUT    4'h7
`define BCT_TC_DATA_IN     4'h8
`define BCT_TC_STATUS      4'h9
`define BCT_TC_MSG_IN      4'hA

// trigger positions
`define BCT_POS_BEFORE     2'h0
`define BCT_POS_CENTERED   2'h1
`define BCT_POS_AFTER      2'h2

// analyzer status
`define BCT_ST_PRE         16'h0000
`define BCT_ST_POST        16'h0001
`define BCT_ST_FULL        16'h0002
`define BCT_ST_STOP        16'h0003

// fetch references
`define BCT_REF_FIRST      2'h0
`define BCT_REF_LAST       2'h1
`define BCT_REF_FWD_TRIG   2'h2
`define BCT_REF_BWD_TRIG   2'h3

// fetch status codes
`define BCT_FS_OK          8'h00
`define BCT_FS_NO_PHASE    8'h40
`define BCT_FS_BAD_TYPE    8'h42
`define BCT_FS_BAD_REF     8'h43
`define BCT_FS_NO_TRIG     8'h44
`define BCT_FS_NO_BYTE     8'h45
`define BCT_FS_NOT_STATE   8'h50
`define BCT_FS_EMPTY       8'hFE

// state line types (bus phase codes on the event record)
`define BCT_PH_ARB         4'h1
`define BCT_PH_ARBWIN      4'h2
`define BCT_PH_SEL         4'h3
`define BCT_PH_RESEL       4'h4
`define BCT_PH_MSG_OUT     4'h5
`define BCT_PH_CMD         4'h6
`define BCT_PH_DATA_OUT    4'h7
`define BCT_PH_DATA_IN     4'h8
`define BCT_PH_STATUS      4'h9
`define BCT_PH_MSG_IN      4'hA

// defaults and limits
`define BCT_DEF_COUNT      16'h0001
`define BCT_MAX_OFFSET     12'hFFF
`define BCT_LINE_BYTES     12'h006
`define BCT_PCT_MAJOR      7'h5F
`define BCT_PCT_FULL       7'h64

`endif

//--- core/bct_trigger.v
// trigger qualifier and occurrence counter
`timescale 1ns/1ps
`include "bct_consts.vh"
module bct_trigger (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        arm,
   input  wire        active,
   input  wire [3:0]  cond,
   input  wire [8:0]  mask,
   input  wire [8:0]  value,
   input  wire [15:0] count,
   input  wire        ev_valid,
   input  wire [3:0]  ev_phase,
   input  wire        ev_xfer,
   input  wire [8:0]  ev_data,
   output reg         fired
);
   reg  [15:0] seen;
   reg         phase_hit;
   wire        data_hit;
   wire        hit;

   // masked bits must equal value; unmasked bits are don't care
   assign data_hit = ((ev_data ^ value) & mask) == 9'h000;

   always @* begin
      case (cond)
         `BCT_TC_ARB:      phase_hit = ev_phase == `BCT_PH_ARB;
         `BCT_TC_SEL:      phase_hit = ev_phase == `BCT_PH_SEL;
         `BCT_TC_RESEL:    phase_hit = ev_phase == `BCT_PH_RESEL;
         `BCT_TC_MSG_OUT,
         `BCT_TC_CMD,
         `BCT_TC_DATA_OUT,
         `BCT_TC_DATA_IN,
         `BCT_TC_STATUS,
         `BCT_TC_MSG_IN:   phase_hit = ev_xfer && (ev_phase == cond);
         default:          phase_hit = 1'b0;
      endcase
   end

   assign hit = active && ev_valid && phase_hit && data_hit;

   always @(posedge core_clk) begin
      if (!rst_n || arm) begin
         fired <= 1'b0;
         seen  <= 16'h0000;
      end else if (!fired && active) begin
         if (cond == `BCT_TC_IMMEDIATE) begin
            fired <= 1'b1;
         end else if (cond != `BCT_TC_NONE) begin
            // count zero fires on the first active cycle, with or without a match
            if (count == 16'h0000) begin
               fired <= 1'b1;
            end else if (hit) begin
               seen <= seen + 16'h0001;
               if (seen + 16'h0001 >= count) begin
                  fired <= 1'b1;
               end
            end
         end
      end
   end
endmodule

//--- test/bct_core_sva.sv
// assertion checker for the capture and trigger control block
`timescale 1ns/1ps
module bct_core_sva #(
   parameter DEPTH_LOG2 = 10,
   parameter PRESENT    = 1
) (
   input wire        core_clk,
   input wire        rst_n,
   input wire [3:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire        ev_valid,
   input wire [3:0]  ev_phase,
   input wire        ev_xfer,
   input wire [8:0]  data_parity_line,
   input wire [15:0] reg_rdata,
   input wire        capturing
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire run_wr = reg_wr && reg_addr == 4'h0;
   wire ok_mode = reg_wdata[1:0] == 2'h1 || reg_wdata[1:0] == 2'h2;
   wire st_rd = reg_rd && reg_addr == 4'h6;
   a_run_starts: assert property (run_wr && ok_mode && PRESENT != 0 |-> ##2 capturing)
      else $error("valid run did not start capture");
   a_bad_mode: assert property (run_wr && !ok_mode && !capturing |-> ##2 !capturing)
      else $error("bad mode started capture");
   a_run_cause: assert property ($rose(capturing) |-> $past(run_wr, 2))
      else $error("capture began without a run write");
   a_length_stop: assert property (reg_rd && reg_addr == 4'h8 |-> ##[1:2] !capturing)
      else $error("length read left capture running");
   a_status_run: assert property (st_rd && capturing |=> reg_rdata[15:1] == 15'h0000)
      else $error("running status code wrong");
   a_status_stop: assert property (st_rd && !capturing && !$past(capturing)
      && !$past(reg_wr) |=> reg_rdata == 16'h0002 || reg_rdata == 16'h0003
      || reg_rdata == 16'hFFFF)
      else $error("stopped status code wrong");
   a_fetch_code: assert property (reg_rd && reg_addr == 4'hC |=> reg_rdata[15:8] inside
      {8'h00, 8'h40, 8'h42, 8'h43, 8'h44, 8'h45, 8'h50, 8'hFE})
      else $error("fetch status outside code set");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 4'hC |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   c_fetch: cover property (reg_rd && reg_addr == 4'hC);
   c_len_stop: cover property (reg_rd && reg_addr == 4'h8 && capturing);
   c_budget_stop: cover property ($fell(capturing) && !$past(reg_rd));
endmodule
bind bct_core bct_core_sva #(.DEPTH_LOG2(DEPTH_LOG2), .PRESENT(PRESENT)) u_bct_core_sva (
   .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .ev_valid(ev_valid), .ev_phase(ev_phase),
   .ev_xfer(ev_xfer), .data_parity_line(data_parity_line), .reg_rdata(reg_rdata),
   .capturing(capturing));

//--- test/bct_bus_model.sv
// behavioural source of events seen on the observed bus
`timescale 1ns/1ps
module bct_bus_model (
   input  wire       core_clk,
   output reg        ev_valid,
   output reg  [3:0] ev_phase,
   output reg        ev_xfer,
   output reg  [8:0] data_parity_line
);
   initial begin
      ev_valid = 1'b0;
      ev_phase = 4'h0;
      ev_xfer = 1'b0;
      data_parity_line = 9'h000;
   end
   task send(input [3:0] ph, input x, input [8:0] d);
      begin
         @(posedge core_clk);
         ev_valid <= 1'b1;
         ev_phase <= ph;
         ev_xfer <= x;
         data_parity_line <= d;
         @(posedge core_clk);
         ev_valid <= 1'b0;
         // lines are not held after the event, so a stale byte must not look valid
         data_parity_line <= ~d;
      end
   endtask
endmodule

//--- test/bus_capture_trigger_control_test.sv
// self-checking bench for the capture and trigger control block
`timescale 1ns/1ps
module bus_capture_trigger_control_test;
   reg         core_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [3:0]  reg_addr = 4'h0;
   reg  [15:0] reg_wdata = 16'h0000;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   wire        ev_valid;
   wire [3:0]  ev_phase;
   wire        ev_xfer;
   wire [8:0]  data_parity_line;
   wire [15:0] reg_rdata;
   wire        capturing;
   reg  [15:0] rv;
   integer     err_count = 0;
   integer     checks_done = 0;
   integer     i;
   integer     k;
   always #20 core_clk = ~core_clk;
   // short buffer keeps the post-trigger budget small
   bct_core #(.DEPTH_LOG2(4)) u_bct_core (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .ev_valid(ev_valid), .ev_phase(ev_phase),
      .ev_xfer(ev_xfer), .data_parity_line(data_parity_line), .reg_rdata(reg_rdata),
      .capturing(capturing));
   bct_bus_model u_bct_bus_model (.core_clk(core_clk), .ev_valid(ev_valid),
      .ev_phase(ev_phase), .ev_xfer(ev_xfer), .data_parity_line(data_parity_line));
   ////////////////////////////////////////
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask
   task chk(input [8*12:1] what, input [15:0] exp, input [15:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge core_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge core_clk);
         reg_wr <= 1'b0;
      end
   endtask
   // data appear on the edge that samples the read and hold until the next read, so sample just past that edge
   task rd(input [3:0] a);
      begin
         @(posedge core_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         #1;
         rv = reg_rdata;
      end
   endtask
   task rdchk(input [3:0] a, input [15:0] exp);
      begin
         rd(a);
         chk("register", exp, rv);
      end
   endtask
   task fetch(input [15:0] c, input [15:0] o, input [15:0] ctl, input [15:0] exp,
              input [15:0] msk);
      begin
         wr(4'hA, c);
         wr(4'hB, o);
         wr(4'h9, ctl);
         rv = 16'h0100;
         for (k = 0; k < 300 && rv[8] !== 1'b0; k = k + 1) begin
            rd(4'h9);
         end
         if (k == 300) begin
            err_count = err_count + 1;
            complete_run;
         end
         rd(4'hC);
         chk("fetch", exp & msk, rv & msk);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      fetch(16'h1, 16'h0, 16'h0060, 16'hFE00, 16'hFF00);
      rdchk(4'hF, 16'h0000);
      wr(4'h0, 16'h0003);
      rdchk(4'h7, 16'hFFFE);
      chk("capturing", 16'h0000, {15'h0, capturing});
      wr(4'h0, 16'h0002);
      tick(2);
      chk("capturing", 16'h0001, {15'h0, capturing});
      rdchk(4'h7, 16'h0000);
      rdchk(4'h6, 16'h0001);
      for (i = 0; i < 6; i = i + 1) begin
         u_bct_bus_model.send(i[3:0] + 4'h1, 1'b0, 9'h000);
      end
      rdchk(4'h8, 16'h0006);
      tick(1);
      chk("capturing", 16'h0000, {15'h0, capturing});
      rdchk(4'h6, 16'h0003);
      fetch(16'h1, 16'h0, 16'h0060, 16'h5000, 16'hFF00);
      // parity masked off, so only the second and third bytes match
      wr(4'h2, 16'h00FF);
      wr(4'h3, 16'h00A5);
      wr(4'h4, 16'h0002);
      wr(4'h1, 16'h0006);
      wr(4'h0, 16'h0002);
      tick(2);
      u_bct_bus_model.send(4'h6, 1'b1, 9'h0A4);
      u_bct_bus_model.send(4'h6, 1'b1, 9'h0A5);
      rdchk(4'h6, 16'h0000);
      u_bct_bus_model.send(4'h6, 1'b1, 9'h1A5);
      rdchk(4'h6, 16'h0001);
      rdchk(4'h8, 16'h0003);
      wr(4'h1, 16'h0001);
      wr(4'h4, 16'h0001);
      wr(4'h5, 16'h0001);
      wr(4'h0, 16'h0002);
      tick(2);
      for (i = 0; i < 7; i = i + 1) begin
         u_bct_bus_model.send(4'h7, 1'b1, 9'h011);
      end
      chk("capturing", 16'h0001, {15'h0, capturing});
      u_bct_bus_model.send(4'h7, 1'b1, 9'h022);
      tick(2);
      chk("capturing", 16'h0000, {15'h0, capturing});
      rdchk(4'h6, 16'h0002);
      wr(4'h1, 16'h0000);
      wr(4'h5, 16'h0000);
      wr(4'h0, 16'h0001);
      tick(2);
      u_bct_bus_model.send(4'h1, 1'b0, 9'h000);
      u_bct_bus_model.send(4'h3, 1'b0, 9'h000);
      for (i = 0; i < 7; i = i + 1) begin
         u_bct_bus_model.send(4'h6, 1'b1, i[8:0] + 9'h010);
      end
      u_bct_bus_model.send(4'h9, 1'b1, 9'h000);
      rdchk(4'h6, 16'h0000);
      rdchk(4'h8, 16'h0004);
      fetch(16'h1, 16'h0, 16'h0060, 16'h0010, 16'hFFFF);
      fetch(16'h1, 16'h6, 16'h0060, 16'h0016, 16'hFFFF);
      fetch(16'h1, 16'h0, 16'h0061, 16'h0010, 16'hFFFF);
      fetch(16'h1, 16'h7, 16'h0060, 16'h4500, 16'hFF00);
      fetch(16'h1, 16'h0, 16'h0000, 16'h4200, 16'hFF00);
      fetch(16'h0, 16'h0, 16'h0060, 16'h4200, 16'hFF00);
      fetch(16'h1, 16'h0, 16'h0064, 16'h4300, 16'hFF00);
      fetch(16'h1, 16'h0, 16'h0062, 16'h4400, 16'hFF00);
      fetch(16'h2, 16'h0, 16'h0060, 16'h4000, 16'hFF00);
      complete_run;
   end
endmodule
